// ---- logic/crsf_pkg.sv ----
package crsf_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] CRSF_ADDR_RXERR   = 8'h00;
	localparam logic [7:0] CRSF_ADDR_TXERR   = 8'h04;
	localparam logic [7:0] CRSF_ADDR_OVWR    = 8'h08;
	localparam logic [7:0] CRSF_ADDR_MASKLO  = 8'h0C;
	localparam logic [7:0] CRSF_ADDR_MASKHI  = 8'h10;
	localparam logic [7:0] CRSF_ADDR_PEND    = 8'h14;
	localparam logic [7:0] CRSF_ADDR_IRQSTAT = 8'h18;
	localparam logic [7:0] CRSF_ADDR_IRQMASK = 8'h1C;

	// ------------------------------------------------------------
	// field layouts and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CRSF_MASKHI_WMASK = 16'hE3FF;
	localparam logic [15:0] CRSF_RST_ZERO16   = 16'h0000;
	localparam logic [7:0]  CRSF_RST_ZERO8    = 8'h00;
	localparam logic [7:0]  CRSF_CNT_MAX      = 8'hFF;
	localparam logic [8:0]  CRSF_TX_BUSOFF    = 9'h100;
	localparam logic [7:0]  CRSF_RX_PASSIVE   = 8'h80;
	localparam logic [7:0]  CRSF_RX_RESTART   = 8'h78;
	localparam logic        CRSF_IRQMASK_RST  = 1'b1;

	// ------------------------------------------------------------
	// fault confinement steps
	// ------------------------------------------------------------
	localparam logic [7:0] CRSF_STEP_ONE   = 8'h01;
	localparam logic [7:0] CRSF_STEP_EIGHT = 8'h08;

	// error counter event codes
	typedef enum logic [2:0] {
		CRSF_EV_NONE    = 3'h0,
		CRSF_EV_RX_ERR  = 3'h1,
		CRSF_EV_RX_ERR8 = 3'h2,
		CRSF_EV_RX_OK   = 3'h3,
		CRSF_EV_TX_ERR8 = 3'h4,
		CRSF_EV_TX_OK   = 3'h5,
		CRSF_EV_BUS_REC = 3'h6
	} crsf_ev_t;

	// saturating add on an 8-bit count
	function automatic logic [7:0] crsf_sat_add(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		crsf_sat_add = s[8] ? CRSF_CNT_MAX : s[7:0];
	endfunction

	// floor-at-zero subtract on an 8-bit count
	function automatic logic [7:0] crsf_sat_sub(input logic [7:0] a,
		input logic [7:0] b);
		crsf_sat_sub = (a > b) ? (a - b) : CRSF_RST_ZERO8;
	endfunction

	// swap bytes: documented words place mailbox/id 7..0 in the top byte
	function automatic logic [15:0] crsf_swap(input logic [15:0] v);
		crsf_swap = {v[7:0], v[15:8]};
	endfunction

endpackage

// ---- logic/crsf_errcnt.sv ----
`timescale 1ns/1ps
// one fault confinement counter, saturating at both ends
module crsf_errcnt
	import crsf_pkg::*;
(
	input  wire logic       sys_clk,  // module clock
	input  wire logic       rstn,     // async reset, active low
	input  wire logic       inc_en,   // add step this cycle
	input  wire logic [7:0] inc_step, // amount to add
	input  wire logic       dec_en,   // subtract one this cycle
	input  wire logic       clr_en,   // force to zero
	input  wire logic       set_en,   // load set_val
	input  wire logic [7:0] set_val,  // value for set_en
	output logic      [7:0] count     // current count
);

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;

	// clear beats load beats increment beats decrement
	assign cnt_nxt = clr_en ? CRSF_RST_ZERO8 :
		set_en ? set_val :
		inc_en ? crsf_sat_add(cnt_r, inc_step) :
		dec_en ? crsf_sat_sub(cnt_r, CRSF_STEP_ONE) : cnt_r;

	// count register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			cnt_r <= CRSF_RST_ZERO8;
		else
			cnt_r <= cnt_nxt;
	end

	assign count = cnt_r;

endmodule // crsf_errcnt

// ---- logic/crsf_idmatch.sv ----
`timescale 1ns/1ps
// mailbox 0 identifier comparator with per-bit don't-care masks
module crsf_idmatch
	import crsf_pkg::*;
(
	input  wire logic [28:0] rx_id,    // received identifier
	input  wire logic [28:0] mb0_id,   // mailbox 0 identifier
	input  wire logic [15:0] mask_lo,  // low mask word
	input  wire logic [15:0] mask_hi,  // high mask word
	output logic             hit       // identifier accepted
);

	logic [15:0] lo_sw;
	logic [15:0] hi_sw;
	logic [28:0] care;

	// reorder mask words into identifier bit order
	assign lo_sw = crsf_swap(mask_lo);
	assign hi_sw = crsf_swap(mask_hi);
	assign care  = ~{hi_sw[15:8], hi_sw[7:5], hi_sw[1:0], lo_sw}; // R8 R9
	assign hit   = ~|((rx_id ^ mb0_id) & care); // R7

endmodule // crsf_idmatch

// ---- logic/crsf_top.sv ----
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// R1: readable receive error count, not writable
// R2: readable transmit error count, not writable
// R3: overwrite flag set on store while pending
// R4: newer message replaces stored unread one
// R5: overwrite flag cleared only by writing one
// R6: status bytes swapped: top byte mailboxes 7..0
// R7: masks apply only to mailbox 0 acceptance
// R8: low mask word maps id 7..0, 15..8
// R9: high mask word maps id 20..16, 28..21
// R10: high mask bits 12..10 read zero
// R11: pending flag set at reception end
// R12: overwrite raises unread interrupt source, maskable
// R13: standard error steps, saturating eight-bit counts
module crsf_top
	import crsf_pkg::*;
(
	input  wire logic        sys_clk,      // 200 MHz module clock
	input  wire logic        rstn,         // async reset, active low
	input  wire logic [7:0]  reg_addr,     // register byte address
	input  wire logic [15:0] reg_wdata,    // write data
	input  wire logic        reg_wr,       // write strobe
	input  wire logic        reg_rd,       // read strobe
	output logic      [15:0] reg_rdata,    // read data, cycle after rd
	input  wire logic        rx_end,       // reception end pulse
	input  wire logic [3:0]  rx_mbox,      // target mailbox of rx_end
	input  wire logic [28:0] rx_id,        // identifier being received
	input  wire logic [28:0] mb0_id,       // mailbox 0 identifier
	output logic             mb0_accept,   // mailbox 0 filter hit
	output logic             store_en,     // write message into ram
	output logic [3:0]       store_mbox,   // mailbox being written
	input  wire logic [15:0] pend_clr,     // pending clear by reader
	output logic [15:0]      pend_flags,   // receive pending flags
	input  wire logic [2:0]  err_event,    // fault confinement event
	output logic             err_passive,  // either count at 128+
	output logic             bus_off,      // transmit step of eight would pass 255
	output logic             irq           // unread (overwrite) interrupt line
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] ovwr_r;
	logic [15:0] ovwr_nxt;
	logic [15:0] mask_lo_r;
	logic [15:0] mask_hi_r;
	logic [15:0] pend_r;
	logic [15:0] pend_nxt;
	logic        unread_src_r;
	logic        unread_src_nxt;
	logic        unread_mask_r;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        store_en_r;
	logic [3:0]  store_mbox_r;
	logic        accept_r;
	logic        passive_r;
	logic        busoff_r;
	logic        irq_r;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic        wr_ovwr;
	logic        wr_masklo;
	logic        wr_maskhi;
	logic        wr_irqmask;
	logic        wr_irqstat;
	logic        rd_irqstat;
	logic [15:0] rx_onehot;
	logic [15:0] ovwr_event;
	logic [15:0] ovwr_clr;
	logic        id_hit;
	logic [7:0]  rx_cnt;
	logic [7:0]  tx_cnt;
	crsf_ev_t    ev;

	assign wr_ovwr    = reg_wr && (reg_addr == CRSF_ADDR_OVWR);
	assign wr_masklo  = reg_wr && (reg_addr == CRSF_ADDR_MASKLO);
	assign wr_maskhi  = reg_wr && (reg_addr == CRSF_ADDR_MASKHI);
	assign wr_irqmask = reg_wr && (reg_addr == CRSF_ADDR_IRQMASK);
	assign wr_irqstat = reg_wr && (reg_addr == CRSF_ADDR_IRQSTAT);
	assign rd_irqstat = reg_rd && (reg_addr == CRSF_ADDR_IRQSTAT);
	assign ev         = crsf_ev_t'(err_event);

	// ------------------------------------------------------------
	// receive pending and overwrite detection
	// ------------------------------------------------------------
	assign rx_onehot  = rx_end ? (16'h0001 << rx_mbox) : CRSF_RST_ZERO16;
	assign ovwr_event = rx_onehot & pend_r; // R3
	// clear word already stands in status order, no reorder
	assign ovwr_clr   = wr_ovwr ? reg_wdata : CRSF_RST_ZERO16;
	// set wins over a clear; events swapped into status order
	assign ovwr_nxt   = (ovwr_r & ~ovwr_clr) | crsf_swap(ovwr_event); // R5 R6
	assign pend_nxt   = (pend_r & ~pend_clr) | rx_onehot; // R11
	// interrupt source: sticky, cleared by reading or writing one
	assign unread_src_nxt = (|ovwr_event) ||
		(unread_src_r && !rd_irqstat &&
		!(wr_irqstat && reg_wdata[0])); // R12

	// identifier comparator for mailbox 0
	crsf_idmatch u_idmatch (
		.rx_id   (rx_id),
		.mb0_id  (mb0_id),
		.mask_lo (mask_lo_r),
		.mask_hi (mask_hi_r),
		.hit     (id_hit)
	);

	// flag registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ovwr_r       <= CRSF_RST_ZERO16;
			pend_r       <= CRSF_RST_ZERO16;
			unread_src_r <= 1'b0;
		end else begin
			ovwr_r       <= ovwr_nxt;
			pend_r       <= pend_nxt;
			unread_src_r <= unread_src_nxt;
		end
	end

	// mask registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mask_lo_r     <= CRSF_RST_ZERO16;
			mask_hi_r     <= CRSF_RST_ZERO16;
			unread_mask_r <= CRSF_IRQMASK_RST;
		end else begin
			if (wr_masklo)
				mask_lo_r <= reg_wdata; // R8
			if (wr_maskhi)
				mask_hi_r <= reg_wdata & CRSF_MASKHI_WMASK; // R10
			if (wr_irqmask)
				unread_mask_r <= reg_wdata[0];
		end
	end

	// store always overwrites: no preservation of unread data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			store_en_r   <= 1'b0;
			store_mbox_r <= 4'h0;
			accept_r     <= 1'b0;
		end else begin
			store_en_r   <= rx_end; // R4
			store_mbox_r <= rx_mbox;
			accept_r     <= id_hit; // R7
		end
	end

	// ------------------------------------------------------------
	// fault confinement counters
	// ------------------------------------------------------------
	logic       rx_inc;
	logic [7:0] rx_step;
	logic       rx_dec;
	logic       rx_set;
	logic       tx_inc;
	logic       tx_dec;
	logic       bus_rec;
	logic [8:0] tx_sum;
	logic       tx_wrap;

	assign rx_inc  = (ev == CRSF_EV_RX_ERR) || (ev == CRSF_EV_RX_ERR8);
	assign rx_step = (ev == CRSF_EV_RX_ERR8) ? CRSF_STEP_EIGHT
		: CRSF_STEP_ONE; // R13
	// success above passive limit drops into 119..127
	assign rx_set  = (ev == CRSF_EV_RX_OK) && (rx_cnt > CRSF_RX_PASSIVE);
	assign rx_dec  = (ev == CRSF_EV_RX_OK); // R13
	assign tx_inc  = (ev == CRSF_EV_TX_ERR8);
	assign tx_dec  = (ev == CRSF_EV_TX_OK); // R13
	assign bus_rec = (ev == CRSF_EV_BUS_REC);
	assign tx_sum  = {1'b0, tx_cnt} + {1'b0, CRSF_STEP_EIGHT};
	assign tx_wrap = tx_inc && (tx_sum >= CRSF_TX_BUSOFF);

	crsf_errcnt u_rxcnt (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.inc_en   (rx_inc),
		.inc_step (rx_step),
		.dec_en   (rx_dec),
		.clr_en   (bus_rec),
		.set_en   (rx_set),
		.set_val  (CRSF_RX_RESTART),
		.count    (rx_cnt)
	); // R1

	crsf_errcnt u_txcnt (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.inc_en   (tx_inc),
		.inc_step (CRSF_STEP_EIGHT),
		.dec_en   (tx_dec),
		.clr_en   (bus_rec),
		.set_en   (1'b0),
		.set_val  (CRSF_RST_ZERO8),
		.count    (tx_cnt)
	); // R2

	// bus-off and passive status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busoff_r  <= 1'b0;
			passive_r <= 1'b0;
		end else begin
			busoff_r  <= bus_rec ? 1'b0 : (busoff_r || tx_wrap);
			passive_r <= (rx_cnt >= CRSF_RX_PASSIVE) ||
				(tx_cnt >= CRSF_RX_PASSIVE);
		end
	end

	// ------------------------------------------------------------
	// read mux, unmapped reads return zero
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = CRSF_RST_ZERO16;
		if (reg_rd) begin
			unique case (reg_addr)
				CRSF_ADDR_RXERR:   rdata_nxt = {8'h00, rx_cnt}; // R1
				CRSF_ADDR_TXERR:   rdata_nxt = {8'h00, tx_cnt}; // R2
				CRSF_ADDR_OVWR:    rdata_nxt = ovwr_r; // R6
				CRSF_ADDR_MASKLO:  rdata_nxt = mask_lo_r;
				CRSF_ADDR_MASKHI:  rdata_nxt = mask_hi_r; // R10
				CRSF_ADDR_PEND:    rdata_nxt = pend_r;
				CRSF_ADDR_IRQSTAT: rdata_nxt = {15'h0000, unread_src_r};
				CRSF_ADDR_IRQMASK: rdata_nxt = {15'h0000, unread_mask_r};
				default:           rdata_nxt = CRSF_RST_ZERO16;
			endcase
		end
	end

	// read data and interrupt output
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= CRSF_RST_ZERO16;
			irq_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			irq_r   <= unread_src_nxt && !unread_mask_r; // R12
		end
	end

	assign reg_rdata   = rdata_r;
	assign mb0_accept  = accept_r;
	assign store_en    = store_en_r;
	assign store_mbox  = store_mbox_r;
	assign pend_flags  = pend_r;
	assign err_passive = passive_r;
	assign bus_off     = busoff_r;
	assign irq         = irq_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ovwr_set: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
		(rx_end && pend_r[rx_mbox]) |=> (ovwr_r != CRSF_RST_ZERO16))
		else $error("overwrite flag not set");
	a_ovwr_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
		(!wr_ovwr && !rx_end) |=> ($past(ovwr_r) == ovwr_r))
		else $error("overwrite flag changed without cause");
	a_pend_set: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
		rx_end |=> pend_r[$past(rx_mbox)])
		else $error("pending flag not set at reception end");
	a_store_follow: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
		rx_end |=> store_en)
		else $error("newer message not stored");
	a_maskhi_rsvd: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
		mask_hi_r[12:10] == 3'h0)
		else $error("reserved mask bits set");
	a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		unread_mask_r |=> !irq)
		else $error("masked interrupt asserted");
	a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		(|ovwr_event && !unread_mask_r) |=> irq)
		else $error("overwrite did not raise interrupt");
	a_rx_sat: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
		(rx_cnt == CRSF_CNT_MAX && rx_inc && !bus_rec) |=>
		(rx_cnt == CRSF_CNT_MAX))
		else $error("receive count wrapped");
	a_tx_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
		(reg_rd && reg_addr == CRSF_ADDR_TXERR) |=>
		(reg_rdata == {8'h00, $past(tx_cnt)}))
		else $error("transmit count read mismatch");

	// overwrite status flags and stored mailbox
	a_ovwr_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
		(wr_ovwr && !rx_end) |=>
		((ovwr_r & $past(reg_wdata)) == CRSF_RST_ZERO16))
		else $error("overwrite flag not cleared by a one");
	a_ovwr_keep: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
		wr_ovwr |=> (($past(ovwr_r) & ~$past(reg_wdata) & ~ovwr_r)
		== CRSF_RST_ZERO16))
		else $error("overwrite flag lost on a zero write");
	a_ovwr_nofalse: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
		(rx_end && !pend_r[rx_mbox] && !wr_ovwr) |=> $stable(ovwr_r))
		else $error("overwrite flag set without pending message");
	a_ovwr_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
		(reg_rd && reg_addr == CRSF_ADDR_OVWR) |=>
		(reg_rdata == $past(ovwr_r)))
		else $error("overwrite status read mismatch");
	a_store_mbox: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
		rx_end |=> (store_mbox == $past(rx_mbox)))
		else $error("stored mailbox number wrong");

	// unread interrupt source and line
	a_irq_source: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		(|ovwr_event) |=> unread_src_r)
		else $error("overwrite did not set unread source");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		irq |-> unread_src_r)
		else $error("interrupt without unread source");

	// mask words
	a_masklo_wr: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
		wr_masklo |=> (mask_lo_r == $past(reg_wdata)))
		else $error("low mask word not written");
	a_maskhi_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
		(reg_rd && reg_addr == CRSF_ADDR_MASKHI) |=>
		(reg_rdata[12:10] == 3'h0))
		else $error("reserved mask bits read nonzero");

	// error counts
	a_rx_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
		(reg_rd && reg_addr == CRSF_ADDR_RXERR) |=>
		(reg_rdata == {8'h00, $past(rx_cnt)}))
		else $error("receive count read mismatch");
	a_rx_nowrite: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
		(reg_wr && ev == CRSF_EV_NONE) |=> $stable(rx_cnt))
		else $error("receive count changed by a write");
	a_tx_nowrite: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
		(reg_wr && ev == CRSF_EV_NONE) |=> $stable(tx_cnt))
		else $error("transmit count changed by a write");
	a_rx_restart: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
		(ev == CRSF_EV_RX_OK && rx_cnt > CRSF_RX_PASSIVE) |=>
		(rx_cnt == CRSF_RX_RESTART))
		else $error("receive count not reloaded above passive");
	a_tx_sat: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
		(tx_cnt == CRSF_CNT_MAX && tx_inc) |=> (tx_cnt == CRSF_CNT_MAX))
		else $error("transmit count wrapped");
	a_busoff_set: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
		tx_wrap |=> bus_off)
		else $error("bus off not flagged");
	a_bus_rec: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
		bus_rec |=> (rx_cnt == CRSF_RST_ZERO8 &&
		tx_cnt == CRSF_RST_ZERO8 && !bus_off))
		else $error("recovery did not clear counts");

endmodule // crsf_top

// ---- verification/crsf_node_model.sv ----
`timescale 1ns/1ps
// other bus nodes: deliver frames and fault confinement events
module crsf_node_model (
	input  wire logic   sys_clk,   // module clock
	output logic        rx_end,    // reception end pulse
	output logic [3:0]  rx_mbox,   // target mailbox of rx_end
	output logic [28:0] rx_id,     // identifier on the bus
	output logic [2:0]  err_event  // fault confinement event
);
	// idle bus at time zero
	initial begin
		rx_end = 1'b0;
		rx_mbox = 4'hF;
		rx_id = 29'h00000000;
		err_event = 3'h0;
	end

	// one finished reception; mailbox released to its inverse
	task automatic send(input logic [3:0] m);
		@(posedge sys_clk);
		rx_end <= 1'b1;
		rx_mbox <= m;
		@(posedge sys_clk);
		rx_end <= 1'b0;
		rx_mbox <= ~m;
	endtask

	// identifier seen by the filter
	task automatic ident(input logic [28:0] id);
		@(posedge sys_clk);
		rx_id <= id;
	endtask

	// one error or success event, one cycle long
	task automatic err(input logic [2:0] e);
		@(posedge sys_clk);
		err_event <= e;
		@(posedge sys_clk);
		err_event <= 3'h0;
	endtask
endmodule // crsf_node_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import crsf_pkg::*;
;
	logic        sys_clk, rstn, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pend_clr, pend_flags;
	logic        rx_end, mb0_accept, store_en, err_passive, bus_off, irq;
	logic [3:0]  rx_mbox, store_mbox;
	logic [28:0] rx_id, mb0_id;
	logic [2:0]  err_event;
	int          n_fail, cmp_count;

	crsf_node_model u_node (.sys_clk(sys_clk), .rx_end(rx_end),
		.rx_mbox(rx_mbox), .rx_id(rx_id), .err_event(err_event));
	crsf_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_end(rx_end), .rx_mbox(rx_mbox),
		.rx_id(rx_id), .mb0_id(mb0_id), .mb0_accept(mb0_accept),
		.store_en(store_en), .store_mbox(store_mbox),
		.pend_clr(pend_clr), .pend_flags(pend_flags),
		.err_event(err_event), .err_passive(err_passive),
		.bus_off(bus_off), .irq(irq));

	// ------------------------------------------------------------
	// clock, reset, shared tasks
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	task automatic end_of_test();
		$display("n_fail %0d cmp_count %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_vals();
		rchk(CRSF_ADDR_RXERR, 16'h0000);
		rchk(CRSF_ADDR_TXERR, 16'h0000);
		rchk(CRSF_ADDR_OVWR, 16'h0000);
		rchk(CRSF_ADDR_MASKLO, 16'h0000);
		rchk(CRSF_ADDR_MASKHI, 16'h0000);
		rchk(CRSF_ADDR_IRQMASK, 16'h0001);
		rchk(8'h20, 16'h0000);
	endtask

	task automatic t_counts();
		u_node.err(3'h1);
		rchk(CRSF_ADDR_RXERR, 16'h0001);
		u_node.err(3'h2);
		u_node.err(3'h3);
		wr(CRSF_ADDR_RXERR, 16'h0055);
		rchk(CRSF_ADDR_RXERR, 16'h0008);
		u_node.err(3'h4);
		u_node.err(3'h5);
		wr(CRSF_ADDR_TXERR, 16'h0055);
		rchk(CRSF_ADDR_TXERR, 16'h0007);
		repeat (32) u_node.err(3'h2);
		rchk(CRSF_ADDR_RXERR, 16'h00FF);
		u_node.err(3'h3);
		rchk(CRSF_ADDR_RXERR, 16'h0078);
		repeat (32) u_node.err(3'h4);
		rchk(CRSF_ADDR_TXERR, 16'h00FF);
		chk(bus_off, 1'b1);
		chk(err_passive, 1'b1);
		u_node.err(3'h6);
		rchk(CRSF_ADDR_RXERR, 16'h0000);
		rchk(CRSF_ADDR_TXERR, 16'h0000);
		chk(bus_off, 1'b0);
	endtask

	// mailbox 3 maps to bit 11, mailbox 12 to bit 4
	task automatic t_overwrite();
		u_node.send(4'h3);
		#1 chk({store_en, store_mbox}, 5'h13);
		rchk(CRSF_ADDR_PEND, 16'h0008);
		rchk(CRSF_ADDR_OVWR, 16'h0000);
		u_node.send(4'h3);
		#1 chk({store_en, store_mbox}, 5'h13);
		rchk(CRSF_ADDR_OVWR, 16'h0800);
		chk(irq, 1'b0);
		u_node.send(4'hC);
		u_node.send(4'hC);
		rchk(CRSF_ADDR_OVWR, 16'h0810);
		wr(CRSF_ADDR_IRQMASK, 16'h0000);
		repeat (2) @(posedge sys_clk);
		#1 chk(irq, 1'b1);
		wr(CRSF_ADDR_OVWR, 16'h0000);
		rchk(CRSF_ADDR_OVWR, 16'h0810);
		wr(CRSF_ADDR_OVWR, 16'h0800);
		rchk(CRSF_ADDR_OVWR, 16'h0010);
		rchk(CRSF_ADDR_IRQSTAT, 16'h0001);
		rchk(CRSF_ADDR_IRQSTAT, 16'h0000);
		#1 chk(irq, 1'b0);
		@(posedge sys_clk);
		pend_clr <= 16'h1008;
		@(posedge sys_clk);
		pend_clr <= 16'h0000;
		u_node.send(4'h3);
		rchk(CRSF_ADDR_OVWR, 16'h0010);
		chk(pend_flags, 16'h0008);
		u_node.send(4'h3);
		#1 chk(irq, 1'b1);
		wr(CRSF_ADDR_IRQSTAT, 16'h0001);
		#1 chk(irq, 1'b0);
		rchk(CRSF_ADDR_IRQSTAT, 16'h0000);
		rchk(CRSF_ADDR_OVWR, 16'h0810);
	endtask

	// reset in mid-run with an overwrite and interrupt pending
	task automatic t_reset_again();
		u_node.send(4'h3);
		#1 chk(irq, 1'b1);
		@(posedge sys_clk);
		rstn <= 1'b0;
		#1 chk(irq, 1'b0);
		chk(pend_flags, 16'h0000);
		chk(mb0_accept, 1'b0);
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		rchk(CRSF_ADDR_OVWR, 16'h0000);
		rchk(CRSF_ADDR_IRQMASK, 16'h0001);
		rchk(CRSF_ADDR_IRQSTAT, 16'h0000);
	endtask

	// one differing identifier bit, then its mask bit set
	task automatic t_masks();
		int idb[7] = '{0, 8, 16, 18, 20, 21, 28};
		int mbit[7] = '{8, 0, 8, 13, 15, 0, 7};
		logic [7:0] ra;
		wr(CRSF_ADDR_MASKHI, 16'hFFFF);
		rchk(CRSF_ADDR_MASKHI, 16'hE3FF);
		wr(CRSF_ADDR_MASKLO, 16'hFFFF);
		rchk(CRSF_ADDR_MASKLO, 16'hFFFF);
		wr(CRSF_ADDR_MASKHI, 16'h0000);
		wr(CRSF_ADDR_MASKLO, 16'h0000);
		@(posedge sys_clk);
		mb0_id <= 29'h0AAAAAAA;
		u_node.ident(29'h0AAAAAAA);
		repeat (2) @(posedge sys_clk);
		#1 chk(mb0_accept, 1'b1);
		for (int i = 0; i < 7; i++) begin
			ra = (idb[i] < 16) ? CRSF_ADDR_MASKLO : CRSF_ADDR_MASKHI;
			u_node.ident(29'h0AAAAAAA ^ (29'h1 << idb[i]));
			repeat (2) @(posedge sys_clk);
			#1 chk(mb0_accept, 1'b0);
			wr(ra, 16'h1 << mbit[i]);
			repeat (2) @(posedge sys_clk);
			#1 chk(mb0_accept, 1'b1);
			wr(ra, 16'h0000);
		end
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		pend_clr = 16'h0000;
		mb0_id = 29'h00000000;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset_vals();
		t_counts();
		t_overwrite();
		t_reset_again();
		t_masks();
		end_of_test();
	end

	initial begin
		#50000;
		n_fail++;
		end_of_test();
	end
endmodule // tb_top
